/* File: include/ntc_pkg.sv */
// nvm table access controller: shared constants, register map, encodings
// assumes a 100 MHz system clock and a word-wide AHB-Lite register bus
package ntc_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CONTROL = 8'h00;
	localparam logic [7:0] OFF_UNLOCK = 8'h04;
	localparam logic [7:0] OFF_ADDRESS = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0c;
	localparam logic [7:0] OFF_LATCH = 8'h10;
	localparam logic [7:0] OFF_POINTER = 8'h14;
	localparam logic [7:0] OFF_FLAGS = 8'h18;
	localparam logic [7:0] OFF_ENABLES = 8'h1c;
	localparam logic [7:0] OFF_PRIORITY = 8'h20;
	localparam logic [7:0] OFF_TABLE_OP = 8'h24;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTL_ASEL = 7;
	localparam int CTL_CSEL = 6;
	localparam int CTL_ERASE = 4;
	localparam int CTL_ABORT = 3;
	localparam int CTL_PERMIT = 2;
	localparam int CTL_WR = 1;
	localparam int CTL_RD = 0;
	localparam int DONE_BIT = 4;
	localparam int OP_LOAD = 0;
	localparam int OP_STORE = 1;
	localparam int PTR_CFG_BIT = 21;
	localparam int ROW_SHIFT = 6;
	localparam int BLOCK_SHIFT = 3;
	localparam int PTR_W = 22;
	localparam int HOLD_COUNT = 8;
	// ----------------------------------------
	// keys, reset values, fixed words
	// ----------------------------------------
	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;
	localparam logic ABORT_RST = 1'b1;
	localparam logic [15:0] NOP_WORD = 16'h0000;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int PROG_TIME_US = 2000;
	localparam int PWRT_TIME_MS = 72;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int PWRT_CYCLES = PWRT_TIME_MS * 1000 * CLK_MHZ;
	// ----------------------------------------
	// encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		TGT_EEPROM = 2'b00,
		TGT_FLASH = 2'b01,
		TGT_CONFIG = 2'b10
	} ntc_target_t;
	typedef enum logic [1:0] {
		UNL_IDLE = 2'b00,
		UNL_GOT1 = 2'b01,
		UNL_ARMED = 2'b10
	} ntc_unlock_t;
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_PROG = 1'b1
	} ntc_state_t;
endpackage : ntc_pkg

/* File: logic/ntc_ctrl.sv */
// nvm table access controller: control register, unlock port, table latch,
// holding registers, self-timed program timer and fetch stall
// assumes an external array port that answers mem_rd combinationally in the same cycle
//
// Behaviour
// - byte reads, byte eeprom writes, 8-byte flash writes, 64-byte erases
// - no bulk erase from user code
// - stall fetches during flash write or erase
// - internal timer ends every write or erase
// - invalid instruction words execute as no-op
// - table load copies pointed byte into latch
// - table store fills holding register by pointer
// - unlock port stores nothing, reads zero
// - array select: zero eeprom, one flash
// - config select overrides array select
// - erase select erases flash or config row, cleared when done
// - write permit gates cycles, cleared at reset
// - abort flag set on trigger, cleared on completion
// - trigger software-settable only, hardware clears
// - done flag set by hardware, software clears
// - read trigger fetches byte, self-clears, eeprom only
// - reset abort clears array and config selects
// - two keys then trigger start a cycle
// - permit must precede trigger write
// - no writes during power-up timer
// - erase row from pointer bits 21 to 6
`timescale 1ns/1ps
`default_nettype none
module ntc_ctrl
	import ntc_pkg::*;
#(
	parameter int PROG_CYC = ntc_pkg::PROG_CYCLES,
	parameter int PWRT_CYC = ntc_pkg::PWRT_CYCLES
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// array port
	output ntc_pkg::ntc_target_t mem_sel,
	output logic [ntc_pkg::PTR_W-1:0] mem_addr,
	output logic mem_rd,
	input wire logic [7:0] mem_rdata,
	output logic mem_wr,
	output logic mem_erase,
	output logic [63:0] mem_wdata,
	// core side
	output logic fetch_stall,
	input wire logic [15:0] insn_in,
	input wire logic insn_invalid,
	output logic [15:0] insn_out
);
	import ntc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] tlatch;
		logic [PTR_W-1:0] ptr;
		logic [7:0] addr;
		logic [7:0] data;
		logic asel;
		logic csel;
		logic erase_sel;
		logic abort;
		logic permit;
		logic wr;
		logic rd;
		logic done_flag;
		logic done_mask;
		logic done_prio;
		logic [HOLD_COUNT-1:0][7:0] hold;
		ntc_unlock_t unl;
		ntc_state_t st;
		logic [31:0] tmr;
		logic [31:0] pwrt;
		logic pwrt_done;
		logic ap_wr;
		logic ap_rd;
		logic ap_hit;
		logic [7:0] ap_addr;
		logic [31:0] rdata;
		logic mem_rd;
		logic mem_wr;
		logic mem_erase;
		logic rd_to_latch;
		ntc_target_t msel;
		logic [PTR_W-1:0] maddr;
		logic [63:0] mwdata;
		logic [15:0] insn;
	} ntc_regs_t;

	ntc_regs_t s;
	ntc_regs_t next_s;
	logic prog_end;
	logic busy;

	assign busy = (s.st == ST_PROG);
	assign prog_end = busy && (s.tmr == 32'(PROG_CYC - 1));

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb
	begin
		logic [7:0] d;
		logic wr_hit;
		logic rd_hit;
		logic unl_kept;
		ntc_target_t tgt;
		d = hwdata[7:0];
		wr_hit = s.ap_wr && s.ap_hit;
		rd_hit = s.ap_rd && s.ap_hit;
		unl_kept = 1'b0;
		tgt = TGT_EEPROM;
		next_s = s;
		next_s.mem_rd = 1'b0;
		next_s.mem_wr = 1'b0;
		next_s.mem_erase = 1'b0;
		next_s.rd = 1'b0;
		next_s.insn = insn_invalid ? NOP_WORD : insn_in;
		if (!s.pwrt_done)
		begin
			next_s.pwrt = s.pwrt + 32'h1;
			next_s.pwrt_done = (s.pwrt == 32'(PWRT_CYC - 1));
		end
		// address phase; reads get one wait state so hrdata leaves a flop
		next_s.ap_wr = 1'b0;
		next_s.ap_rd = 1'b0;
		if (hsel && htrans[1] && hready)
		begin
			next_s.ap_wr = hwrite;
			next_s.ap_rd = !hwrite;
			next_s.ap_hit = (haddr[31:8] == 24'h0) && (haddr[1:0] == 2'b00);
			next_s.ap_addr = haddr[7:0];
		end
		// a read captured in an array cycle lands in latch or data register
		if (s.mem_rd)
		begin
			if (s.rd_to_latch)
				next_s.tlatch = mem_rdata;
			else
				next_s.data = mem_rdata;
		end
		if (rd_hit)
		begin
			unique case (s.ap_addr)
				OFF_CONTROL: next_s.rdata = {24'h0, s.asel, s.csel, 1'b0, s.erase_sel, s.abort,
					s.permit, s.wr, s.rd};
				OFF_ADDRESS: next_s.rdata = {24'h0, s.addr};
				OFF_DATA: next_s.rdata = {24'h0, s.data};
				OFF_LATCH: next_s.rdata = {24'h0, s.tlatch};
				OFF_POINTER: next_s.rdata = {10'h0, s.ptr};
				OFF_FLAGS: next_s.rdata = 32'(s.done_flag) << DONE_BIT;
				OFF_ENABLES: next_s.rdata = 32'(s.done_mask) << DONE_BIT;
				OFF_PRIORITY: next_s.rdata = 32'(s.done_prio) << DONE_BIT;
				default: next_s.rdata = 32'h0;
			endcase
		end
		else if (s.ap_rd)
			next_s.rdata = 32'h0;
		if (wr_hit)
		begin
			unique case (s.ap_addr)
				OFF_UNLOCK:
				begin
					unl_kept = 1'b1;
					if (s.unl == UNL_IDLE && d == KEY_FIRST)
						next_s.unl = UNL_GOT1;
					else if (s.unl == UNL_GOT1 && d == KEY_SECOND)
						next_s.unl = UNL_ARMED;
					else
						next_s.unl = UNL_IDLE;
				end
				OFF_CONTROL:
				begin
					if (!busy)
					begin
						next_s.asel = d[CTL_ASEL];
						next_s.csel = d[CTL_CSEL];
						next_s.erase_sel = d[CTL_ERASE];
						next_s.abort = d[CTL_ABORT];
						next_s.permit = d[CTL_PERMIT];
						// trigger needs permit already set by an earlier write
						if (d[CTL_WR] && s.permit)
						begin
							next_s.abort = 1'b1;
							if (s.unl == UNL_ARMED && s.pwrt_done)
							begin
								next_s.wr = 1'b1;
								next_s.st = ST_PROG;
								next_s.tmr = 32'h0;
								// config select wins over array select
								tgt = d[CTL_CSEL] ? TGT_CONFIG : (d[CTL_ASEL] ? TGT_FLASH : TGT_EEPROM);
								next_s.msel = tgt;
								if (tgt == TGT_EEPROM)
								begin
									next_s.maddr = PTR_W'(s.addr);
									next_s.mwdata = {56'h0, s.data};
									next_s.mem_wr = 1'b1;
								end
								else if (d[CTL_ERASE])
								begin
									// only a single row erase exists; no bulk path
									next_s.maddr = (s.ptr >> ROW_SHIFT) << ROW_SHIFT;
									next_s.mem_erase = 1'b1;
								end
								else
								begin
									next_s.maddr = (s.ptr >> BLOCK_SHIFT) << BLOCK_SHIFT;
									next_s.mwdata = s.hold;
									next_s.mem_wr = 1'b1;
								end
							end
						end
						// eeprom read only; refused when flash or config selected
						if (d[CTL_RD] && !d[CTL_ASEL] && !d[CTL_CSEL] && !next_s.mem_wr)
						begin
							next_s.rd = 1'b1;
							next_s.mem_rd = 1'b1;
							next_s.rd_to_latch = 1'b0;
							next_s.msel = TGT_EEPROM;
							next_s.maddr = PTR_W'(s.addr);
						end
					end
				end
				OFF_ADDRESS:
				begin
					if (!busy)
						next_s.addr = d;
				end
				OFF_DATA:
				begin
					if (!busy)
						next_s.data = d;
				end
				OFF_LATCH: next_s.tlatch = d;
				OFF_POINTER: next_s.ptr = hwdata[PTR_W-1:0];
				OFF_FLAGS: next_s.done_flag = d[DONE_BIT];
				OFF_ENABLES: next_s.done_mask = d[DONE_BIT];
				OFF_PRIORITY: next_s.done_prio = d[DONE_BIT];
				OFF_TABLE_OP:
				begin
					if (!busy)
					begin
						if (d[OP_LOAD])
						begin
							next_s.mem_rd = 1'b1;
							next_s.rd_to_latch = 1'b1;
							next_s.msel = (s.csel || s.ptr[PTR_CFG_BIT]) ? TGT_CONFIG : TGT_FLASH;
							next_s.maddr = s.ptr;
						end
						// alignment of code bytes is left to software
						if (d[OP_STORE])
							next_s.hold[s.ptr[BLOCK_SHIFT-1:0]] = s.tlatch;
					end
				end
				default:
				begin
				end
			endcase
		end
		// any access that is not the next key drops the sequence
		if ((s.ap_wr || s.ap_rd) && !unl_kept)
			next_s.unl = UNL_IDLE;
		// self-timed end; hardware events win over same-cycle software clears
		if (busy)
		begin
			next_s.tmr = s.tmr + 32'h1;
			if (prog_end)
			begin
				next_s.st = ST_IDLE;
				next_s.wr = 1'b0;
				next_s.abort = 1'b0;
				next_s.done_flag = 1'b1;
				if (s.msel != TGT_EEPROM && s.erase_sel)
					next_s.erase_sel = 1'b0;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// abort flag comes up set so a reset during a cycle is always visible;
	// selects are cleared by reset along with everything else, so the failed target is not kept
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s <= '0;
			s.abort <= ABORT_RST;
			s.msel <= TGT_EEPROM;
			s.unl <= UNL_IDLE;
			s.st <= ST_IDLE;
		end
		else
			s <= next_s;
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign hrdata = s.rdata;
	assign hreadyout = !s.ap_rd;
	assign hresp = 1'b0;
	assign mem_sel = s.msel;
	assign mem_addr = s.maddr;
	assign mem_rd = s.mem_rd;
	assign mem_wr = s.mem_wr;
	assign mem_erase = s.mem_erase;
	assign mem_wdata = s.mwdata;
	assign fetch_stall = busy && (s.msel != TGT_EEPROM);
	assign insn_out = s.insn;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_start_keyed: assert property ($rose(busy) |-> $past(s.unl) == UNL_ARMED && $past(s.permit) && s.pwrt_done)
		else $error("cycle started without key sequence");
	a_stall_flash: assert property ((s.mem_erase || (s.mem_wr && s.msel != TGT_EEPROM)) |-> fetch_stall)
		else $error("flash cycle without fetch stall");
	a_rd_selfclear: assert property (s.rd |-> !s.asel && !s.csel ##1 !s.rd)
		else $error("read trigger misbehaved");
	a_unlock_zero: assert property ((s.ap_rd && s.ap_addr == OFF_UNLOCK) |=> hreadyout && hrdata == 32'h0)
		else $error("unlock port read not zero");
	a_done_sets: assert property (prog_end |=> s.done_flag && !s.wr && !s.abort && !busy)
		else $error("completion did not update flags");
	a_abort_on_wr: assert property ($rose(s.wr) |-> s.abort && $past(s.permit))
		else $error("trigger without abort flag or permit");
	a_wr_held: assert property ((s.wr && !prog_end) |=> s.wr)
		else $error("trigger cleared early");
	a_erase_row: assert property (s.mem_erase |-> s.maddr[ROW_SHIFT-1:0] == '0 && s.msel != TGT_EEPROM)
		else $error("erase address not row aligned");
	a_erase_clears: assert property ((prog_end && s.erase_sel && s.msel != TGT_EEPROM) |=> !s.erase_sel)
		else $error("erase select not cleared");
	a_busy_frozen: assert property ((busy && !prog_end) |=> $stable(s.addr) && $stable(s.data) && $stable(s.asel))
		else $error("registers changed while busy");
	a_pwrt_block: assert property (!s.pwrt_done |-> !busy)
		else $error("write during power-up interval");
	a_insn_nop: assert property (insn_invalid |=> insn_out == NOP_WORD)
		else $error("invalid word not turned into no-op");
	a_latch_load: assert property ((s.mem_rd && s.rd_to_latch) |=> s.tlatch == $past(mem_rdata))
		else $error("latch not loaded");

	c_eeprom_write: cover property ($rose(busy) && s.msel == TGT_EEPROM);
	c_row_erase: cover property (s.mem_erase ##[1:3] busy);
	c_eeprom_read: cover property (s.rd && s.mem_rd);
	c_done: cover property (prog_end ##1 s.done_flag);
endmodule : ntc_ctrl
`default_nettype wire

/* File: testbench/ntc_mem_model.sv */
// array stand-in: answers byte reads at once, records writes and erases
// assumes one-cycle mem_rd, mem_wr and mem_erase pulses from the controller
`timescale 1ns/1ps
`default_nettype none
module ntc_mem_model
	import ntc_pkg::*;
(
	// clock
	input wire logic mclk,
	// array port
	input wire ntc_pkg::ntc_target_t mem_sel,
	input wire logic [21:0] mem_addr,
	input wire logic mem_rd,
	output logic [7:0] mem_rdata,
	input wire logic mem_wr,
	input wire logic mem_erase,
	input wire logic [63:0] mem_wdata,
	// observation
	output int wr_n,
	output int er_n,
	output int rd_n,
	output ntc_pkg::ntc_target_t wsel,
	output ntc_pkg::ntc_target_t rsel,
	output logic [21:0] waddr,
	output logic [63:0] wdata
);
	logic [7:0] last = 8'h00;
	// not read: show the inverse of the last byte, never a stale copy
	assign mem_rdata = mem_rd ? (mem_addr[7:0] ^ 8'h5a) : ~last;
	// counters are two-state and start at zero
	always @(posedge mclk)
	begin
		if (mem_rd)
		begin
			last <= mem_rdata;
			rd_n <= rd_n + 1;
			rsel <= mem_sel;
		end
		if (mem_wr || mem_erase)
		begin
			wr_n <= wr_n + int'(mem_wr);
			er_n <= er_n + int'(mem_erase);
			wsel <= mem_sel;
			waddr <= mem_addr;
			wdata <= mem_wdata;
		end
	end
endmodule : ntc_mem_model
`default_nettype wire

/* File: testbench/nvm_table_access_control_tb.sv */
// bench for the nvm table access controller over ahb-lite
// assumes hreadyout is fed back as hready, one slave on the bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module nvm_table_access_control_tb;
	import ntc_pkg::*;
	logic mclk, rst, hsel, hwrite, hreadyout, hresp, mem_rd, mem_wr, mem_erase, fetch_stall, insn_invalid, stall_seen;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	ntc_target_t mem_sel, wsel, rsel;
	logic [21:0] mem_addr, waddr;
	logic [7:0] mem_rdata;
	logic [63:0] mem_wdata, wdata;
	logic [15:0] insn_in, insn_out;
	int num_errors, n_checks, wr_n, er_n, rd_n;
	// ----------------------------------------
	// design and array
	// ----------------------------------------
	ntc_ctrl #(.PROG_CYC(40), .PWRT_CYC(4)) DUT (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .mem_sel(mem_sel), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_erase(mem_erase), .mem_wdata(mem_wdata),
		.fetch_stall(fetch_stall), .insn_in(insn_in), .insn_invalid(insn_invalid), .insn_out(insn_out));
	ntc_mem_model mem (.mclk(mclk), .mem_sel(mem_sel), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_erase(mem_erase), .mem_wdata(mem_wdata), .wr_n(wr_n),
		.er_n(er_n), .rd_n(rd_n), .wsel(wsel), .rsel(rsel), .waddr(waddr), .wdata(wdata));
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		if (rst === 1'b1)
			stall_seen <= 1'b0;
		else if (fetch_stall === 1'b1)
			stall_seen <= 1'b1;
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	// entered just after a rising edge; ready and read data are taken as sampled at the edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'b00;
		hwdata <= d;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		r = hrdata;
		if (hreadyout !== 1'b1)
			num_errors++;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic unlock(input logic [31:0] c);
		wr(OFF_UNLOCK, {24'h0, KEY_FIRST});
		wr(OFF_UNLOCK, {24'h0, KEY_SECOND});
		wr(OFF_CONTROL, c);
	endtask : unlock
	task automatic wait_done;
		int n = 0;
		do
		begin
			rd(OFF_CONTROL);
			n++;
		end
		while (r[1] !== 1'b0 && n < 60);
		if (r[1] !== 1'b0)
			num_errors++;
	endtask : wait_done
	task automatic final_report;
		if (num_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report
	initial
	begin
		#200000;
		num_errors++;
		final_report;
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		{rst, hsel, hwrite, insn_invalid} = 4'b1100;
		{haddr, hwdata, htrans, insn_in} = '0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(OFF_CONTROL); `CHK("ctl_rst", 32'h08, r)
		`CHK("hresp", 1'b0, hresp)
		wr(OFF_UNLOCK, 32'h55); rd(OFF_UNLOCK); `CHK("unlock_rd", 32'h0, r)
		rd(8'h3c); `CHK("unmapped", 32'h0, r)
		wr(OFF_CONTROL, 32'h06); rd(OFF_CONTROL); `CHK("wr_with_permit", 32'h04, r)
		wr(OFF_CONTROL, 32'h06); rd(OFF_CONTROL); `CHK("no_keys", 32'h0c, r)
		wr(OFF_ADDRESS, 32'h33);
		wr(OFF_DATA, 32'hc5);
		unlock(32'h06);
		wr(OFF_CONTROL, 32'h0);
		wr(OFF_ADDRESS, 32'h77);
		rd(OFF_CONTROL); `CHK("busy_ctl", 32'h0e, r)
		wait_done; `CHK("ee_done", 32'h04, r)
		`CHK("ee_cnt", 1, wr_n)
		`CHK("ee_addr", 22'h33, waddr)
		`CHK("ee_data", 8'hc5, wdata[7:0])
		`CHK("ee_sel", TGT_EEPROM, wsel)
		`CHK("ee_stall", 1'b0, stall_seen)
		rd(OFF_ADDRESS); `CHK("addr_kept", 32'h33, r)
		rd(OFF_FLAGS); `CHK("done_set", 32'h10, r)
		wr(OFF_FLAGS, 32'h0); rd(OFF_FLAGS); `CHK("done_clr", 32'h0, r)
		wr(OFF_ADDRESS, 32'h21);
		wr(OFF_CONTROL, 32'h01);
		rd(OFF_DATA); `CHK("ee_rd", 32'h7b, r)
		wr(OFF_CONTROL, 32'h81); rd(OFF_CONTROL); `CHK("rd_refused", 32'h80, r)
		`CHK("rd_cnt", 1, rd_n)
		// fill the eight holding bytes, one per low pointer value
		for (int i = 0; i < 8; i++)
		begin
			wr(OFF_POINTER, 32'h105a8 + i);
			wr(OFF_LATCH, 32'h10 + i);
			wr(OFF_TABLE_OP, 32'h2);
		end
		wr(OFF_CONTROL, 32'h84);
		unlock(32'h86);
		wait_done; `CHK("fl_done", 32'h84, r)
		`CHK("fl_cnt", 2, wr_n)
		`CHK("fl_addr", 22'h105a8, waddr)
		`CHK("fl_data", 64'h1716151413121110, wdata)
		`CHK("fl_sel", TGT_FLASH, wsel)
		`CHK("fl_stall", 1'b1, stall_seen)
		wr(OFF_POINTER, 32'h2abcd);
		wr(OFF_CONTROL, 32'h94);
		unlock(32'h96);
		wait_done; `CHK("er_done", 32'h84, r)
		`CHK("er_cnt", 1, er_n)
		`CHK("er_addr", 22'h2abc0, waddr)
		wr(OFF_CONTROL, 32'hc0);
		wr(OFF_POINTER, 32'h01234);
		wr(OFF_TABLE_OP, 32'h1);
		rd(OFF_LATCH); `CHK("latch", 32'h6e, r)
		`CHK("cfg_sel", TGT_CONFIG, rsel)
		wr(OFF_CONTROL, 32'h80);
		wr(OFF_TABLE_OP, 32'h1);
		rd(OFF_CONTROL); `CHK("fl_rsel", TGT_FLASH, rsel)
		wr(OFF_CONTROL, 32'hc4);
		wr(OFF_CONTROL, 32'hc6);
		rd(OFF_CONTROL); `CHK("abort_sel", 32'hcc, r)
		`CHK("abort_cnt", 2, wr_n)
		insn_in <= 16'habcd;
		insn_invalid <= 1'b1;
		@(posedge mclk);
		@(negedge mclk); `CHK("insn_nop", 16'h0, insn_out)
		@(posedge mclk);
		insn_invalid <= 1'b0;
		@(posedge mclk);
		@(negedge mclk); `CHK("insn_ok", 16'habcd, insn_out)
		// reset in the middle of a flash cycle must leave the abort flag up
		@(posedge mclk);
		wr(OFF_CONTROL, 32'h84);
		unlock(32'h86);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(OFF_CONTROL); `CHK("rst_mid", 32'h08, r)
		`CHK("stall_rst", 1'b0, fetch_stall)
		final_report;
	end
endmodule : nvm_table_access_control_tb
`default_nettype wire
